// ==== src/cal_crc_params.svh ====
/*
 * Constants of the calibration and register-map check block: byte indices of
 * the register map, field positions, reset values and arithmetic constants.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef CAL_CRC_PARAMS_SVH
`define CAL_CRC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address on the bus is four times the index)
// ----------------------------------------------------------------------------
`define IDX_REVISION        4'h0
`define IDX_STATUS          4'h2
`define IDX_CONTROL         4'h3
`define IDX_FOURTH_CONFIGURATION_REGISTER         4'h8
`define IDX_OFFSET_HIGH     4'h9
`define IDX_OFFSET_MID      4'ha
`define IDX_OFFSET_LOW      4'hb
`define IDX_GAIN_HIGH       4'hc
`define IDX_GAIN_MID        4'hd
`define IDX_GAIN_LOW        4'he
`define IDX_CHECK_VALUE     4'hf

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define CFG4_CHECK_EN_BIT   1
`define CFG4_RESERVED_MASK  8'hef
`define CFG4_RESET          8'h00
`define STATUS_REGERR_BIT   5
`define OFFSET_BYTE_RESET   8'h00
`define GAIN_HIGH_RESET     8'h40
`define GAIN_LOW_RESET      8'h00
`define CHECK_VALUE_RESET   8'h00

// ----------------------------------------------------------------------------
// Arithmetic constants
// ----------------------------------------------------------------------------
`define GAIN_UNITY          24'h400000
`define GAIN_SHIFT          22
`define CRC_POLY            8'h07
`define CRC_INIT            8'hff
`define CRC_BYTE_COUNT      4'hd
`define CRC_LAST_STEP       4'hc

`endif

// ==== src/cal_crc_pkg.sv ====
/*
 * Types shared by the calibration and register-map check block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package cal_crc_pkg;

    // Conversion sample with its valid strobe
    typedef struct packed {
        logic        valid;
        logic [23:0] data;
    } sample_s;

    // Register-map scanner states
    typedef enum logic [1:0] {
        SCAN_IDLE  = 2'b00,
        SCAN_RUN   = 2'b01,
        SCAN_CHECK = 2'b10
    } scan_e;

endpackage : cal_crc_pkg

`default_nettype wire

// ==== src/calibration_and_regmap_crc.sv ====
/*
 * Post-filter offset/gain calibration datapath and register-map checksum
 * checker, with an APB slave for its registers.
 * Assumes: one 20 MHz clock, synchronous active-high reset, samples and the
 * other configuration bytes synchronous to core_clk.
 */
// Overview of operation
// - 24-bit two's-complement offset subtracted from samples
// - Offset applied first, then gain
// - Gain word unsigned, 400000h means unity
// - Output equals offset-removed data times gain/400000h
// - Offset bytes at 9h..Bh, reset zero
// - Gain bytes at Ch..Eh, reset 40h,00h,00h
// - Check value register at Fh, read/write
// - Checksum covers 00h..0Eh except 02h, 03h
// - Checksum recomputed and compared continuously while enabled
// - Mismatch sets flag in status and header
// - Flag sticky until host writes one
// - No other action taken on mismatch
// - Compare only while enable bit is one
// - Checksum is CRC remainder using XOR arithmetic
// - Generator polynomial x^8 + x^2 + x + 1
// - Checksum shift register preset to all ones
// - Enable is fourth_configuration_register bit 1, resets zero
`include "cal_crc_params.svh"
`default_nettype none

module calibration_and_regmap_crc
    import cal_crc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // Covered configuration bytes held elsewhere in the device
    input  wire logic [7:0]        silicon_revision_code,
    input  wire logic [39:0]       other_config_bytes,
    // Sample path
    input  wire sample_s           sample_in,
    output sample_s                sample_out,
    // Status header byte and configuration view
    output logic [7:0]             status_header,
    output logic [7:0]             fourth_configuration_register
);

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    logic [7:0]  cal_q [6];
    logic [7:0]  cfg4_q;
    logic [7:0]  check_value_q;
    logic        regerr_q;
    logic [23:0] offset_word;
    logic [23:0] gain_word;
    logic        check_en;

    assign offset_word = {cal_q[0], cal_q[1], cal_q[2]};
    assign gain_word   = {cal_q[3], cal_q[4], cal_q[5]};
    assign check_en    = cfg4_q[`CFG4_CHECK_EN_BIT];

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    logic       setup_ph;
    logic       wr_acc;
    logic [3:0] reg_idx;
    logic       upper_zero;
    logic       mapped;
    logic       wr_byte;

    assign setup_ph   = psel && !penable;
    assign wr_acc     = psel && penable && pwrite && mapped && wr_byte;
    assign reg_idx    = paddr[5:2];
    assign upper_zero = (paddr[ADDR_W-1:6] == '0);
    assign wr_byte    = pstrb[0];
    // Zero wait states: every access completes in its first access cycle
    assign pready     = 1'b1;

    // Only the registers this block owns answer; the rest signal an error
    always_comb begin
        mapped = 1'b0;
        if (upper_zero) begin
            case (reg_idx)
                `IDX_STATUS, `IDX_FOURTH_CONFIGURATION_REGISTER, `IDX_OFFSET_HIGH, `IDX_OFFSET_MID,
                `IDX_OFFSET_LOW, `IDX_GAIN_HIGH, `IDX_GAIN_MID, `IDX_GAIN_LOW,
                `IDX_CHECK_VALUE: mapped = 1'b1;
                default:          mapped = 1'b0;
            endcase
        end
    end

    // Read mux, reserved and upper bits read as zero
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        case (reg_idx)
            `IDX_STATUS:      rd_byte = 8'(regerr_q) << `STATUS_REGERR_BIT;
            `IDX_FOURTH_CONFIGURATION_REGISTER:     rd_byte = cfg4_q;
            `IDX_OFFSET_HIGH: rd_byte = cal_q[0];
            `IDX_OFFSET_MID:  rd_byte = cal_q[1];
            `IDX_OFFSET_LOW:  rd_byte = cal_q[2];
            `IDX_GAIN_HIGH:   rd_byte = cal_q[3];
            `IDX_GAIN_MID:    rd_byte = cal_q[4];
            `IDX_GAIN_LOW:    rd_byte = cal_q[5];
            `IDX_CHECK_VALUE: rd_byte = check_value_q;
            default:          rd_byte = 8'h00;
        endcase
    end

    // Read data and error captured in the setup cycle so they come from flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata  <= (mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            pslverr <= !mapped;
        end
    end

    // ------------------------------------------------------------------------
    // Calibration bytes, one entry per register
    // ------------------------------------------------------------------------
    localparam logic [7:0] CAL_RESET [6] = '{`OFFSET_BYTE_RESET, `OFFSET_BYTE_RESET, `OFFSET_BYTE_RESET,
                                            `GAIN_HIGH_RESET, `GAIN_LOW_RESET, `GAIN_LOW_RESET};

    for (genvar k = 0; k < 6; k++) begin : g_cal
        // Byte k sits at index 9h + k
        always_ff @(posedge core_clk) begin
            if (rst) begin
                cal_q[k] <= CAL_RESET[k];
            end else if (wr_acc && reg_idx == 4'(`IDX_OFFSET_HIGH + k)) begin
                cal_q[k] <= pwdata[7:0];
            end
        end
    end

    // Fourth_configuration_register and the check value
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg4_q        <= `CFG4_RESET;
            check_value_q <= `CHECK_VALUE_RESET;
        end else if (wr_acc) begin
            if (reg_idx == `IDX_FOURTH_CONFIGURATION_REGISTER) begin
                cfg4_q <= pwdata[7:0] & `CFG4_RESERVED_MASK;
            end
            if (reg_idx == `IDX_CHECK_VALUE) begin
                check_value_q <= pwdata[7:0];
            end
        end
    end

    assign fourth_configuration_register = cfg4_q;

    // ------------------------------------------------------------------------
    // Calibration datapath
    // ------------------------------------------------------------------------
    // Clip a wide signed value into the signed 24-bit output range
    function automatic logic [23:0] clip24(input logic signed [48:0] v);
        logic [23:0] r;
        r = v[23:0];
        if (v > 49'sh0_0000_007f_ffff) begin
            r = 24'h7fffff;
        end else if (v < -49'sh0_0000_0080_0000) begin
            r = 24'h800000;
        end
        return r;
    endfunction

    logic signed [24:0] diff;
    logic signed [48:0] product;
    logic signed [48:0] scaled;
    logic [23:0]        s1_data_q;
    logic               s1_valid_q;

    assign diff    = $signed({sample_in.data[23], sample_in.data}) - $signed({offset_word[23], offset_word});
    assign product = $signed(s1_data_q) * $signed({1'b0, gain_word});
    assign scaled  = product >>> `GAIN_SHIFT;  // Truncates toward minus infinity

    // Stage one removes the offset before any scaling
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1_valid_q <= 1'b0;
            s1_data_q  <= 24'h00_0000;
        end else begin
            s1_valid_q <= sample_in.valid;
            if (sample_in.valid) begin
                s1_data_q <= clip24(49'(diff));
            end
        end
    end

    // Stage two scales by gain/400000h
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sample_out <= '0;
        end else begin
            sample_out.valid <= s1_valid_q;
            if (s1_valid_q) begin
                sample_out.data <= clip24(scaled);
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register-map checksum scanner
    // ------------------------------------------------------------------------
    // One CRC byte step, MSB first, XOR division by the generator
    function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[7] ^ b[i]) begin
                r = {r[6:0], 1'b0} ^ `CRC_POLY;
            end else begin
                r = {r[6:0], 1'b0};
            end
        end
        return r;
    endfunction

    // The covered bytes: steps 0 and 1 map to indices 0 and 1, later steps to index step + 2, skipping status and control
    logic [7:0] map_byte;
    logic [3:0] step_q;
    logic [3:0] cover_idx;

    assign cover_idx = (step_q < 4'h2) ? step_q : 4'(step_q + 4'h2);

    always_comb begin
        map_byte = 8'h00;
        case (cover_idx)
            `IDX_REVISION:    map_byte = silicon_revision_code;
            4'h1:             map_byte = other_config_bytes[7:0];
            4'h4:             map_byte = other_config_bytes[15:8];
            4'h5:             map_byte = other_config_bytes[23:16];
            4'h6:             map_byte = other_config_bytes[31:24];
            4'h7:             map_byte = other_config_bytes[39:32];
            `IDX_FOURTH_CONFIGURATION_REGISTER:     map_byte = cfg4_q;
            `IDX_OFFSET_HIGH: map_byte = cal_q[0];
            `IDX_OFFSET_MID:  map_byte = cal_q[1];
            `IDX_OFFSET_LOW:  map_byte = cal_q[2];
            `IDX_GAIN_HIGH:   map_byte = cal_q[3];
            `IDX_GAIN_MID:    map_byte = cal_q[4];
            `IDX_GAIN_LOW:    map_byte = cal_q[5];
            default:          map_byte = 8'h00;
        endcase
    end

    // A change under a running pass would compare a torn snapshot, so restart
    logic [47:0] ext_q;
    logic        restart;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_q <= 48'h0000_0000_0000;
        end else begin
            ext_q <= {silicon_revision_code, other_config_bytes};
        end
    end
    assign restart = wr_acc || (ext_q != {silicon_revision_code, other_config_bytes});

    scan_e      scan_q;
    logic [7:0] crc_q;
    logic       mismatch;

    assign mismatch = (scan_q == SCAN_CHECK) && check_en && (crc_q != check_value_q);

    // Free-running passes while enabled, no trigger needed
    always_ff @(posedge core_clk) begin
        if (rst) begin
            scan_q <= SCAN_IDLE;
            step_q <= 4'h0;
            crc_q  <= `CRC_INIT;
        end else if (!check_en || restart) begin
            scan_q <= check_en ? SCAN_RUN : SCAN_IDLE;
            step_q <= 4'h0;
            crc_q  <= `CRC_INIT;
        end else begin
            case (scan_q)
                SCAN_IDLE: begin
                    scan_q <= SCAN_RUN;
                    step_q <= 4'h0;
                    crc_q  <= `CRC_INIT;
                end
                SCAN_RUN: begin
                    crc_q <= crc8_step(crc_q, map_byte);
                    if (step_q == `CRC_LAST_STEP) begin
                        scan_q <= SCAN_CHECK;
                    end else begin
                        step_q <= step_q + 4'h1;
                    end
                end
                SCAN_CHECK: begin
                    scan_q <= SCAN_RUN;
                    step_q <= 4'h0;
                    crc_q  <= `CRC_INIT;
                end
                default: begin
                    scan_q <= SCAN_IDLE;
                    step_q <= 4'h0;
                    crc_q  <= `CRC_INIT;
                end
            endcase
        end
    end

    // Sticky error: a mismatch in the clearing cycle still sets the flag
    logic clear_err;
    assign clear_err = wr_acc && (reg_idx == `IDX_STATUS) && pwdata[`STATUS_REGERR_BIT];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            regerr_q <= 1'b0;
        end else begin
            regerr_q <= mismatch || (regerr_q && !clear_err);
        end
    end

    assign status_header = 8'(regerr_q) << `STATUS_REGERR_BIT;

    // Cycles of one unbroken pass, so the length check needs no long repetition
    logic [3:0] run_len_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            run_len_q <= 4'h0;
        end else if (scan_q == SCAN_RUN && check_en && !restart) begin
            run_len_q <= run_len_q + 4'h1;
        end else begin
            run_len_q <= 4'h0;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    offset_first_a: assert property (@(posedge core_clk) disable iff (rst)
        $past(sample_in.valid) |-> s1_data_q == clip24(49'($signed({$past(sample_in.data[23]), $past(sample_in.data)})
                                   - $signed({$past(offset_word[23]), $past(offset_word)}))))
        else $error("offset not removed from sample");

    gain_after_offset_a: assert property (@(posedge core_clk) disable iff (rst)
        sample_in.valid |-> ##2 sample_out.valid)
        else $error("calibrated sample not two cycles after input");

    unity_gain_a: assert property (@(posedge core_clk) disable iff (rst)
        s1_valid_q && gain_word == `GAIN_UNITY |=> sample_out.data == $past(s1_data_q))
        else $error("unity gain changed the sample");

    gain_scale_a: assert property (@(posedge core_clk) disable iff (rst)
        s1_valid_q && gain_word == 24'h200000 && !s1_data_q[23] |=> sample_out.data == ($past(s1_data_q) >> 1))
        else $error("half gain not applied");

    offset_reset_a: assert property (@(posedge core_clk)
        $past(rst) |-> offset_word == 24'h000000)
        else $error("offset not zero after reset");

    gain_reset_a: assert property (@(posedge core_clk)
        $past(rst) |-> gain_word == `GAIN_UNITY && !check_en)
        else $error("gain or enable wrong after reset");

    check_off_a: assert property (@(posedge core_clk) disable iff (rst)
        !check_en && !regerr_q |=> !regerr_q)
        else $error("error flagged while check disabled");

    err_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
        regerr_q && !clear_err |=> regerr_q)
        else $error("error flag dropped without clear");

    mismatch_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        mismatch |=> regerr_q && status_header[`STATUS_REGERR_BIT])
        else $error("mismatch did not set error flag");

    pass_length_a: assert property (@(posedge core_clk) disable iff (rst)
        scan_q == SCAN_CHECK |-> run_len_q == `CRC_BYTE_COUNT)
        else $error("checksum pass not thirteen bytes");

endmodule : calibration_and_regmap_crc

`default_nettype wire

// ==== verification/host_model.sv ====
/*
 * Host processor model: APB master tasks, a shadow of the bytes it wrote and
 * the register-map checksum that it computes before writing the check value.
 * Assumes the slave samples on core_clk rising edges and answers with pready.
 */
`include "cal_crc_params.svh"
`default_nettype none

module host_model (
    // Clock
    input  wire logic        core_clk,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    // Bytes held elsewhere in the device
    input  wire logic [7:0]  silicon_revision_code,
    input  wire logic [39:0] other_config_bytes
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    logic [7:0] shadow [16];

    // Idle bus and reset values of the written bytes
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        foreach (shadow[i]) shadow[i] = 8'h00;
        shadow[12] = 8'h40;
    end

    // Request held until pready is seen; only the bench timeout ends a hang
    task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {6'h00, idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        pstrb   <= 4'hf;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (wr && err !== 1'b1) shadow[idx] = wd;
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        logic        e;
        xfer(1'b1, idx, wd, d, e);
    endtask

    task automatic rd(input logic [3:0] idx, output logic [31:0] d, output logic e);
        xfer(1'b0, idx, 8'h00, d, e);
    endtask

    // ------------------------------------------------------------------
    // Checksum the host writes
    // ------------------------------------------------------------------
    // Revision byte taken live from the device, never assumed
    function automatic logic [7:0] calc_check();
        logic [7:0] c;
        logic [7:0] b;
        c = 8'hff;
        for (int i = 0; i < 15; i++) begin
            if (i == 2 || i == 3) continue;
            if (i == 0) b = silicon_revision_code;
            else if (i == 1) b = other_config_bytes[7:0];
            else if (i < 8) b = other_config_bytes[8*(i-3) +: 8];
            else if (i == 8) b = (shadow[8] | 8'h02) & 8'hef;
            else b = shadow[i];
            for (int j = 7; j >= 0; j--)
                c = {c[6:0], 1'b0} ^ ({8{c[7] ^ b[j]}} & 8'h07);
        end
        return c;
    endfunction
endmodule // host_model

`default_nettype wire

// ==== verification/testbench.sv ====
/*
 * Self-checking bench: register resets, refused address, calibration
 * arithmetic with clipping, and the register-map check flag.
 * Assumes host_model drives APB; samples and covered bytes come from here.
 */
`include "cal_crc_params.svh"
`default_nettype none

`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("FAIL %s exp %0h got %0h", nm, ex, gt); end end

module testbench;
    import cal_crc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [7:0]  rev, status_header, cfg4;
    logic [39:0] other;
    sample_s     sample_in, sample_out;
    int          error_cnt = 0;
    int          compares = 0;

    calibration_and_regmap_crc i_dut (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .silicon_revision_code(rev), .other_config_bytes(other),
        .sample_in(sample_in), .sample_out(sample_out),
        .status_header(status_header), .fourth_configuration_register(cfg4));

    host_model i_host (
        .core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .silicon_revision_code(rev),
        .other_config_bytes(other));

    // 20 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // Reference arithmetic
    // ------------------------------------------------------------------
    function automatic longint clip(longint v);
        if (v > 64'sd8388607) return 64'sd8388607;
        if (v < -64'sd8388608) return -64'sd8388608;
        return v;
    endfunction

    // Floor of the scaled value, matching a right shift of the product
    function automatic logic [23:0] cal_ref(logic signed [23:0] x, logic signed [23:0] off,
                                            logic [23:0] g);
        longint s;
        s = clip(longint'(x) - longint'(off));
        s = clip((s * longint'({1'b0, g})) >>> 22);
        return s[23:0];
    endfunction

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [7:0]  ex [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
        logic [31:0] d;
        logic        e;
        for (int i = 0; i < 8; i++) begin
            i_host.rd(4'(8 + i), d, e);
            `CHK("reset byte", {24'h000000, ex[i]}, d)
        end
        i_host.rd(`IDX_STATUS, d, e);
        `CHK("status reset", 32'h0, d)
    endtask

    // Unmapped index refused with an error and zero data
    task automatic t_unmapped();
        logic [31:0] d;
        logic        e;
        i_host.rd(4'h1, d, e);
        `CHK("slverr", 1'b1, e)
        `CHK("slverr data", 32'h0, d)
    endtask

    task automatic send(input logic [23:0] x, input logic [23:0] ex);
        int n;
        @(posedge core_clk);
        sample_in <= {1'b1, x};
        @(posedge core_clk);
        sample_in.valid <= 1'b0;
        n = 0;
        while (sample_out.valid !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            n++;
        end
        `CHK("latency", 2, n)
        `CHK("sample", ex, sample_out.data)
    endtask

    // Two's-complement offset, order of operations, floor and both clips
    task automatic t_cal();
        logic [23:0] x [7] = '{24'h01e240, 24'h000064, 24'hfffffd, 24'h800000, 24'h700000, 24'h7fffff, 24'h000065};
        logic [23:0] o [7] = '{24'h000000, 24'hfffff0, 24'h000000, 24'h000001, 24'h000000, 24'h800000, 24'h000000};
        logic [23:0] g [7] = '{24'h400000, 24'h600000, 24'h600000, 24'h600000, 24'h7fffff, 24'h400000, 24'h200000};
        for (int i = 0; i < 7; i++) begin
            for (int k = 0; k < 3; k++) begin
                i_host.wr(4'(9 + k), o[i][23-8*k -: 8]);
                i_host.wr(4'(12 + k), g[i][23-8*k -: 8]);
            end
            send(x[i], cal_ref(x[i], o[i], g[i]));
        end
        `CHK("plain case", 24'h0000ae, cal_ref(24'h64, 24'hfffff0, 24'h600000))
    endtask

    // Matching value, mismatch, sticky flag, clear and disabled check
    task automatic t_check();
        logic [31:0] d;
        logic        e;
        logic [7:0]  good;
        int          n;
        good = i_host.calc_check();
        i_host.wr(`IDX_CHECK_VALUE, good);
        i_host.wr(`IDX_FOURTH_CONFIGURATION_REGISTER, 8'h02);
        i_host.rd(`IDX_FOURTH_CONFIGURATION_REGISTER, d, e);
        `CHK("cfg4 read", 32'h2, d)
        `CHK("cfg4 port", 8'h02, cfg4)
        repeat (40) @(posedge core_clk);
        `CHK("no flag", 8'h00, status_header)
        i_host.wr(`IDX_CHECK_VALUE, good ^ 8'h01);
        n = 0;
        while (status_header[5] !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        `CHK("header flag", 8'h20, status_header)
        i_host.rd(`IDX_STATUS, d, e);
        `CHK("status flag", 32'h20, d)
        i_host.rd(`IDX_FOURTH_CONFIGURATION_REGISTER, d, e);
        `CHK("cfg4 kept", 32'h2, d)
        // Host corrects the value before clearing, else the flag returns
        i_host.wr(`IDX_CHECK_VALUE, good);
        repeat (40) @(posedge core_clk);
        `CHK("sticky", 8'h20, status_header)
        i_host.wr(`IDX_STATUS, 8'h20);
        repeat (40) @(posedge core_clk);
        `CHK("cleared", 8'h00, status_header)
        i_host.wr(`IDX_FOURTH_CONFIGURATION_REGISTER, 8'h00);
        i_host.wr(`IDX_CHECK_VALUE, good ^ 8'h01);
        repeat (40) @(posedge core_clk);
        `CHK("disabled", 8'h00, status_header)
    endtask

    // ------------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------------
    task automatic conclude();
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Revision and other bytes are arbitrary test values
    initial begin
        rst = 1'b1;
        sample_in = '0;
        rev = 8'h5a;
        other = 40'h1122334455;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_unmapped();
        t_cal();
        t_check();
        conclude();
    end

    // Run needs about 400 cycles; 40000 means a hang
    initial begin
        #2000000;
        error_cnt++;
        conclude();
    end
endmodule // testbench

`default_nettype wire
